// [hdl/hcs_synth_latch_control.sv]
// synthesizer programming latches, power-down control, dividers, lock detect
// assumes all pins synchronous to mclk; ref_in and fb_in are level inputs
module hcs_synth_latch_control
   import hcs_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic chip_enable,
   input wire logic ref_in,
   input wire logic fb_in,
   output logic powered_down,
   output logic ref_buffer_en,
   output logic rf_out_en,
   output logic pump_tristate,
   output logic pump_up,
   output logic pump_dn,
   output logic [2:0] pump_current,
   output logic lock_detect,
   output logic output_halve,
   output logic halved_feedback_select,
   output logic [5:0] prescaler_modulus,
   output logic [1:0] out_level,
   output logic [1:0] core_level,
   output logic [2:0] mux_select,
   output logic [1:0] backlash_width,
   output logic ref_div_out,
   output logic band_clk
);
   hcs_ctrl_type ctrl, next_ctrl;
   hcs_fb_type fbw, next_fbw;
   hcs_ref_type refw, next_refw;
   logic pump_gain, next_pump_gain;
   logic [WORD_W-1:0] rx_word;
   logic rx_valid;
   logic [1:0] addr;

   hcs_serial_rx u_rx (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .load_strobe(load_strobe),
      .word(rx_word),
      .word_valid(rx_valid)
   );

   assign addr = rx_word[1:0];

   // latches: each keeps its value until a word with its address arrives, except pump_gain, which control and feedback words both load
   always_comb begin
      next_ctrl = ctrl;
      next_fbw = fbw;
      next_refw = refw;
      next_pump_gain = pump_gain;
      if (rx_valid) begin
         unique case (addr)
            ADDR_CTRL: begin
               next_ctrl = hcs_ctrl_type'(rx_word);
               next_pump_gain = next_ctrl.pump_gain_select;
            end
            ADDR_REF: next_refw = hcs_ref_type'(rx_word);
            ADDR_FB: begin
               next_fbw = hcs_fb_type'(rx_word);
               next_pump_gain = next_fbw.pump_gain_select;
            end
            // test latch contents are never used by normal operation
            default: next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl <= CTRL_RST;
         fbw <= FB_RST;
         refw <= REF_RST;
         pump_gain <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         fbw <= next_fbw;
         refw <= next_refw;
         pump_gain <= next_pump_gain;
      end
   end

   // input edges in the mclk domain
   logic ref_q, fb_q, ref_tick, fb_tick;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ref_q <= 1'b0;
         fb_q <= 1'b0;
      end else begin
         ref_q <= ref_in;
         fb_q <= fb_in;
      end
   end
   assign ref_tick = ref_in && !ref_q;
   assign fb_tick = fb_in && !fb_q;

   // power-down state
   hcs_pwr_type pwr, next_pwr;
   logic [1:0] sync_cnt, next_sync_cnt;
   logic down_now, ctrl_load, r_pulse, n_pulse;

   assign ctrl_load = rx_valid && addr == ADDR_CTRL;

   always_comb begin
      next_pwr = pwr;
      next_sync_cnt = sync_cnt;
      if (ctrl_load) begin
         next_sync_cnt = '0;
         if (!next_ctrl.powerdown_trigger) begin
            next_pwr = PWR_ON;
         end else if (!next_ctrl.powerdown_sync_select) begin
            next_pwr = PWR_DOWN;
         end else begin
            next_pwr = PWR_SYNC;
         end
      end else if (pwr == PWR_SYNC && r_pulse) begin
         // gated by the reference output so the loop does not jump
         if (sync_cnt + 2'h1 >= SYNC_EDGES) begin
            next_pwr = PWR_DOWN;
         end else begin
            next_sync_cnt = sync_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pwr <= PWR_ON;
         sync_cnt <= '0;
      end else begin
         pwr <= next_pwr;
         sync_cnt <= next_sync_cnt;
      end
   end

   // hardware pin overrides both software bits
   assign down_now = !chip_enable || pwr == PWR_DOWN;

   // dividers
   logic cnt_clear;
   logic [18:0] n_ratio, next_n_ratio;
   assign cnt_clear = ctrl.counter_clear || down_now;

   hcs_tick_div #(.W(14)) u_rdiv (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(ref_tick),
      .clear(cnt_clear),
      .ratio(refw.ref_count),
      .pulse(r_pulse)
   );

   // N = P*B + A, from the 5-bit A and 13-bit B fields
   always_comb begin
      next_n_ratio = 19'(hcs_modulus(ctrl.prescaler) * fbw.b_count)
                   + 19'(fbw.a_count);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         n_ratio <= '0;
      end else begin
         n_ratio <= next_n_ratio;
      end
   end

   hcs_tick_div #(.W(19)) u_ndiv (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(fb_tick),
      .clear(cnt_clear),
      .ratio(n_ratio),
      .pulse(n_pulse)
   );

   // band select clock: reference output, optionally divided
   logic [3:0] band_cnt, next_band_cnt;
   logic next_band_clk;
   always_comb begin
      next_band_cnt = band_cnt;
      next_band_clk = 1'b0;
      if (down_now) begin
         next_band_cnt = '0;
      end else if (r_pulse) begin
         if (band_cnt + 4'h1 >= hcs_band_ratio(refw.band_clock_divider)) begin
            next_band_cnt = '0;
            next_band_clk = 1'b1;
         end else begin
            next_band_cnt = band_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         band_cnt <= '0;
         band_clk <= 1'b0;
      end else begin
         band_cnt <= next_band_cnt;
         band_clk <= next_band_clk;
      end
   end

   // phase detector and digital lock detect
   logic pfd_up, pfd_dn, next_pfd_up, next_pfd_dn;
   logic pend, next_pend;
   logic [3:0] gap, next_gap;
   logic [2:0] good, next_good;
   logic locked, next_locked;
   logic [2:0] need;
   assign need = refw.lock_precision ? LOCK_CNT_FINE : LOCK_CNT_COARSE;

   always_comb begin
      next_pfd_up = pfd_up || r_pulse;
      next_pfd_dn = pfd_dn || n_pulse;
      if (next_pfd_up && next_pfd_dn) begin
         next_pfd_up = 1'b0;
         next_pfd_dn = 1'b0;
      end
      next_pend = pend;
      next_gap = gap;
      next_good = good;
      next_locked = locked;
      if (r_pulse && n_pulse) begin
         next_pend = 1'b0;
         next_good = (good < need) ? good + 3'h1 : good;
      end else if (r_pulse || n_pulse) begin
         if (pend) begin
            next_pend = 1'b0;
            next_good = (good < need) ? good + 3'h1 : good;
         end else begin
            next_pend = 1'b1;
            next_gap = '0;
         end
      end else if (pend) begin
         if (gap >= 4'(LOCK_WIN_CYC)) begin
            // edges too far apart: start counting again
            next_pend = 1'b0;
            next_good = '0;
            next_locked = 1'b0;
         end else begin
            next_gap = gap + 4'h1;
         end
      end
      if (next_good >= need) begin
         next_locked = 1'b1;
      end
      if (down_now) begin
         next_pfd_up = 1'b0;
         next_pfd_dn = 1'b0;
         next_pend = 1'b0;
         next_good = '0;
         next_locked = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pfd_up <= 1'b0;
         pfd_dn <= 1'b0;
         pend <= 1'b0;
         gap <= '0;
         good <= '0;
         locked <= 1'b0;
      end else begin
         pfd_up <= next_pfd_up;
         pfd_dn <= next_pfd_dn;
         pend <= next_pend;
         gap <= next_gap;
         good <= next_good;
         locked <= next_locked;
      end
   end

   // registered outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         powered_down <= 1'b1;
         ref_buffer_en <= 1'b0;
         rf_out_en <= 1'b0;
         pump_tristate <= 1'b1;
         pump_up <= 1'b0;
         pump_dn <= 1'b0;
         pump_current <= '0;
         lock_detect <= 1'b0;
         output_halve <= 1'b0;
         halved_feedback_select <= 1'b0;
         prescaler_modulus <= '0;
         out_level <= '0;
         core_level <= '0;
         mux_select <= '0;
         backlash_width <= '0;
         ref_div_out <= 1'b0;
      end else begin
         powered_down <= down_now;
         ref_buffer_en <= !down_now;
         rf_out_en <= !down_now && (!ctrl.mute_until_locked || locked);
         pump_tristate <= down_now || ctrl.pump_float;
         pump_up <= ctrl.detector_polarity ? pfd_up : pfd_dn;
         pump_dn <= ctrl.detector_polarity ? pfd_dn : pfd_up;
         pump_current <= pump_gain ? ctrl.pump_current_two
                                   : ctrl.pump_current_code;
         // cleared in the same edge as powered_down so the two never disagree
         lock_detect <= locked && !down_now;
         output_halve <= fbw.output_halve;
         halved_feedback_select <= fbw.halved_feedback_select;
         prescaler_modulus <= hcs_modulus(ctrl.prescaler);
         out_level <= ctrl.out_level;
         core_level <= ctrl.core_level;
         mux_select <= ctrl.mux_select;
         backlash_width <= refw.backlash_width;
         ref_div_out <= r_pulse;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_ctrl_load: assert property (rx_valid && addr == ADDR_CTRL |=> ctrl == $past(rx_word))
      else $error("control word not loaded");
   a_ref_load: assert property (rx_valid && addr == ADDR_REF |=> refw == $past(rx_word))
      else $error("reference word not loaded");
   a_fb_load: assert property (rx_valid && addr == ADDR_FB |=> fbw == $past(rx_word))
      else $error("feedback word not loaded");
   a_fb_hold: assert property (!(rx_valid && addr == ADDR_FB) |=> $stable(fbw))
      else $error("feedback word changed without a write");
   a_async_down: assert property (ctrl_load && next_ctrl.powerdown_trigger
      && !next_ctrl.powerdown_sync_select && chip_enable |=> ##1 powered_down)
      else $error("asynchronous power-down late");
   a_sync_wait: assert property (ctrl_load && next_ctrl.powerdown_trigger
      && next_ctrl.powerdown_sync_select |=> pwr == PWR_SYNC)
      else $error("synchronous power-down not gated");
   a_pin_down: assert property (!chip_enable |=> powered_down && !rf_out_en)
      else $error("chip enable low did not disable");
   a_down_effects: assert property (powered_down |-> pump_tristate && !ref_buffer_en
      && !lock_detect)
      else $error("power-down effects missing");
   a_gain_latest: assert property (rx_valid && addr == ADDR_FB
      |=> pump_gain == $past(rx_word[21]))
      else $error("gain copy not updated");
   a_mute_lock: assert property (rf_out_en && $past(ctrl.mute_until_locked)
      |-> $past(locked))
      else $error("output on before lock");
   a_current_sel: assert property (##1 pump_current == ($past(pump_gain)
      ? $past(ctrl.pump_current_two) : $past(ctrl.pump_current_code)))
      else $error("wrong pump current setting");
endmodule

// [hdl/hcs_pkg.sv]
// constants, word layouts and decode helpers for the synthesizer latch block
// assumes one 250 MHz clock; all pins already synchronous to it
package hcs_pkg;
   localparam int WORD_W = 24;
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_REF = 2'h1;
   localparam logic [1:0] ADDR_FB = 2'h2;
   localparam int CLK_PERIOD_NS = 4;
   localparam int LOCK_ERR_NS = 15;
   // longest allowed error, rounded down to whole cycles
   localparam int LOCK_WIN_CYC = (LOCK_ERR_NS / CLK_PERIOD_NS < 1) ? 1
                                 : LOCK_ERR_NS / CLK_PERIOD_NS;
   localparam logic [2:0] LOCK_CNT_FINE = 3'h5;
   localparam logic [2:0] LOCK_CNT_COARSE = 3'h3;
   localparam logic [1:0] SYNC_EDGES = 2'h2;

   typedef struct packed {
      logic [1:0] prescaler;
      logic powerdown_sync_select;
      logic powerdown_trigger;
      logic [2:0] pump_current_two;
      logic [2:0] pump_current_code;
      logic [1:0] out_level;
      logic mute_until_locked;
      logic pump_gain_select;
      logic pump_float;
      logic detector_polarity;
      logic [2:0] mux_select;
      logic counter_clear;
      logic [1:0] core_level;
      logic [1:0] latch_address;
   } hcs_ctrl_type;

   typedef struct packed {
      logic halved_feedback_select;
      logic output_halve;
      logic pump_gain_select;
      logic [12:0] b_count;
      logic spare;
      logic [4:0] a_count;
      logic [1:0] latch_address;
   } hcs_fb_type;

   typedef struct packed {
      logic [1:0] spare;
      logic [1:0] band_clock_divider;
      logic factory_test_flag;
      logic lock_precision;
      logic [1:0] backlash_width;
      logic [13:0] ref_count;
      logic [1:0] latch_address;
   } hcs_ref_type;

   localparam hcs_ctrl_type CTRL_RST = '0;
   localparam hcs_fb_type FB_RST = '0;
   localparam hcs_ref_type REF_RST = '0;

   typedef enum logic [1:0] {
      PWR_ON = 2'b00,
      PWR_SYNC = 2'b01,
      PWR_DOWN = 2'b10
   } hcs_pwr_type;

   function automatic logic [5:0] hcs_modulus(input logic [1:0] code);
      unique case (code)
         2'h0: hcs_modulus = 6'h08;
         2'h1: hcs_modulus = 6'h10;
         default: hcs_modulus = 6'h20;
      endcase
   endfunction

   function automatic logic [3:0] hcs_band_ratio(input logic [1:0] code);
      hcs_band_ratio = 4'h1 << code;
   endfunction
endpackage

// [hdl/hcs_serial_rx.sv]
// serial input register: 24-bit shifter and load strobe edge detect
// assumes serial pins are synchronous to mclk and slower than it
module hcs_serial_rx
   import hcs_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe,
   output logic [WORD_W-1:0] word,
   output logic word_valid
);
   logic sclk_q, strobe_q;
   logic [WORD_W-1:0] shift;
   logic [WORD_W-1:0] next_shift, next_word;
   logic next_valid;

   // never gated by power-down, so words still land while powered off
   always_comb begin
      next_shift = shift;
      next_word = word;
      next_valid = 1'b0;
      if (serial_clk && !sclk_q) begin
         next_shift = {shift[WORD_W-2:0], serial_data};
      end
      if (load_strobe && !strobe_q) begin
         next_word = shift;
         next_valid = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sclk_q <= 1'b0;
         strobe_q <= 1'b0;
         shift <= '0;
         word <= '0;
         word_valid <= 1'b0;
      end else begin
         sclk_q <= serial_clk;
         strobe_q <= load_strobe;
         shift <= next_shift;
         word <= next_word;
         word_valid <= next_valid;
      end
   end
endmodule

// [hdl/hcs_tick_div.sv]
// programmable divider of input ticks; emits one pulse per ratio ticks
// assumes tick is a one-cycle pulse; clear holds the load state
module hcs_tick_div #(
   parameter int W = 14
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic clear,
   input wire logic [W-1:0] ratio,
   output logic pulse
);
   logic [W-1:0] cnt, next_cnt;
   logic next_pulse;

   always_comb begin
      next_cnt = cnt;
      next_pulse = 1'b0;
      if (clear) begin
         next_cnt = '0;
      end else if (tick) begin
         // a ratio of zero behaves as one rather than never firing
         if (cnt + W'(1) >= ratio) begin
            next_cnt = '0;
            next_pulse = 1'b1;
         end else begin
            next_cnt = cnt + W'(1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt <= '0;
         pulse <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pulse <= next_pulse;
      end
   end
endmodule

// [tb/hcs_host_model.sv]
// host model: drives the three-wire programming link one word at a time
// assumes the bench calls send_word; link clock and strobe idle low between words
module hcs_host_model
   import hcs_pkg::*;
#(
   parameter int SETTLE_NS = 400
) (
   input wire logic mclk,
   output logic serial_clk,
   output logic serial_data,
   output logic load_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   time last_ctrl = 0;
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   task automatic edges(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // hold sets cycles per link level, so one model serves fast and slow hosts
   task automatic send_word(input logic [WORD_W-1:0] w, input int hold);
      int i;
      if (w[1:0] == ADDR_REF) w[19] = 1'b0;
      // settling gap shrunk to keep runs short; real parts want milliseconds
      while (w[1:0] == ADDR_FB && $time - last_ctrl < SETTLE_NS) edges(1);
      for (i = WORD_W - 1; i >= 0; i--) begin
         serial_data = w[i];
         edges(hold);
         serial_clk = 1'b1;
         edges(hold);
         serial_clk = 1'b0;
      end
      edges(hold);
      load_strobe = 1'b1;
      edges(hold);
      load_strobe = 1'b0;
      // released data line must not keep looking like the last bit
      serial_data = ~w[0];
      if (w[1:0] == ADDR_CTRL) last_ctrl = $time;
   endtask
endmodule

// [tb/tb_synth_latch_control.sv]
// self-checking bench for the synthesizer latch block
// assumes the host model drives the link; the reference input is made here
module tb_synth_latch_control
   import hcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [23:0] word;
      logic [2:0] cur;
      logic [5:0] pm;
      logic [1:0] ol;
      logic [1:0] cl;
      logic [2:0] mx;
      logic [1:0] bw;
      logic oh;
      logic hs;
      logic tri_st;
      logic pd;
   } hcs_row_type;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic chip_enable = 1'b1;
   logic ref_in = 1'b0;
   logic fb_in = 1'b0;
   logic ref_run = 1'b0;
   logic fb_run = 1'b0;
   logic [3:0] ref_ph = 4'h0;
   logic serial_clk, serial_data, load_strobe;
   logic powered_down, ref_buffer_en, rf_out_en, pump_tristate, pump_up, pump_dn;
   logic lock_detect, output_halve, halved_feedback_select, ref_div_out, band_clk;
   logic [2:0] pump_current, mux_select;
   logic [5:0] prescaler_modulus;
   logic [1:0] out_level, core_level, backlash_width;
   int failures = 0;
   int tests_run = 0;
   int nr, nt, nb, early;
   // the reference word still loads while powered down
   hcs_row_type rows [9] = '{
      '{24'h4aa164, 3'h2, 6'h10, 2'h2, 2'h1, 3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{24'ha0037e, 3'h5, 6'h10, 2'h2, 2'h1, 3'h3, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{24'h360005, 3'h5, 6'h10, 2'h2, 2'h1, 3'h3, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0},
      '{24'hffffff, 3'h5, 6'h10, 2'h2, 2'h1, 3'h3, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0},
      '{24'h81d60c, 3'h0, 6'h20, 2'h1, 2'h3, 3'h0, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0},
      '{24'h5fff02, 3'h7, 6'h20, 2'h1, 2'h3, 3'h0, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0},
      '{24'h100000, 3'h0, 6'h08, 2'h0, 2'h0, 3'h0, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1},
      '{24'h300005, 3'h0, 6'h08, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1},
      '{24'h4aa164, 3'h2, 6'h10, 2'h2, 2'h1, 3'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0}
   };
   logic [23:0] band_word [2] = '{24'h360005, 24'h10000d};
   int band_pulses [2] = '{8, 2};
   int band_ticks [2] = '{8, 6};

   always #2 mclk = ~mclk;
   // reference tick every 16 cycles; feedback copies it one cycle late
   always @(posedge mclk) begin
      #1;
      ref_ph <= ref_ph + 4'h1;
      ref_in <= ref_run & ref_ph[3];
      fb_in <= fb_run & ref_in;
   end

   hcs_host_model i_host (.mclk, .serial_clk, .serial_data, .load_strobe);
   hcs_synth_latch_control i_dut (
      .mclk, .sys_rst, .serial_clk, .serial_data, .load_strobe, .chip_enable,
      .ref_in, .fb_in, .powered_down, .ref_buffer_en, .rf_out_en, .pump_tristate,
      .pump_up, .pump_dn, .pump_current, .lock_detect, .output_halve,
      .halved_feedback_select, .prescaler_modulus, .out_level, .core_level,
      .mux_select, .backlash_width, .ref_div_out, .band_clk
   );

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic load(input logic [23:0] w, input int hold);
      i_host.send_word(w, hold);
      cyc(6);
   endtask
   task automatic chk_row(input hcs_row_type r);
      chk("pump_current", 8'(r.cur), 8'(pump_current));
      chk("prescaler", 8'(r.pm), 8'(prescaler_modulus));
      chk("out_level", 8'(r.ol), 8'(out_level));
      chk("core_level", 8'(r.cl), 8'(core_level));
      chk("mux_select", 8'(r.mx), 8'(mux_select));
      chk("backlash", 8'(r.bw), 8'(backlash_width));
      chk("halving", 8'({r.oh, r.hs}), 8'({output_halve, halved_feedback_select}));
      chk("pump_tri", 8'(r.tri_st), 8'(pump_tristate));
      chk("powered_down", 8'(r.pd), 8'(powered_down));
      chk("out_enables", 8'({2{!r.pd}}), 8'({ref_buffer_en, rf_out_en}));
   endtask
   // counts reference ticks and divider pulses between two band clock pulses
   task automatic walk(input int lim);
      logic prev;
      int i;
      prev = ref_in;
      nr = 0;
      nt = 0;
      nb = 0;
      for (i = 0; i < lim && nb < 2; i++) begin
         cyc(1);
         if (ref_in === 1'b1 && prev === 1'b0) nt++;
         prev = ref_in;
         if (ref_div_out === 1'b1) nr++;
         if (band_clk === 1'b1) begin
            nb++;
            nr = (nb == 1) ? 0 : nr;
            nt = (nb == 1) ? 0 : nt;
         end
      end
   endtask

   initial begin
      int i;
      cyc(1);
      chk("rst_state", 8'({powered_down, pump_tristate, rf_out_en, ref_buffer_en}), 8'h0c);
      cyc(2);
      sys_rst = 1'b0;
      cyc(1);
      for (i = 0; i < 9; i++) begin
         load(rows[i].word, 2 + 3 * (i % 2));
         chk_row(rows[i]);
      end
      chip_enable = 1'b0;
      cyc(3);
      chk("ce_low", 8'({powered_down, pump_tristate, rf_out_en, ref_buffer_en}), 8'h0c);
      chip_enable = 1'b1;
      load(24'h4aa164, 2);
      chk("ce_high", 8'(powered_down), 8'h00);
      load(24'h000800, 2);
      chk("muted", 8'(rf_out_en), 8'h00);
      load(24'h000010, 2);
      ref_run = 1'b1;
      walk(200);
      chk("cleared", 8'(nr), 8'h00);
      load(24'h4aa164, 2);
      for (i = 0; i < 2; i++) begin
         load(band_word[i], 2);
         walk(600);
         chk("band_seen", 8'(nb), 8'h02);
         if (nb != 2) close_out();
         chk("band_ratio", 8'(nr), 8'(band_pulses[i]));
         chk("ref_ratio", 8'(nt), 8'(band_ticks[i]));
      end
      ref_run = 1'b0;
      load(24'h300000, 2);
      chk("sync_wait", 8'(powered_down), 8'h00);
      ref_run = 1'b1;
      nr = 0;
      early = 0;
      for (i = 0; i < 300 && nr < 2; i++) begin
         cyc(1);
         if (powered_down !== 1'b0) early++;
         if (ref_div_out === 1'b1) nr++;
      end
      chk("sync_seen", 8'(nr), 8'h02);
      if (nr != 2) close_out();
      cyc(3);
      chk("sync_early", 8'(early), 8'h00);
      chk("sync_down", 8'({powered_down, pump_tristate, lock_detect}), 8'h06);
      // ticks stopped so both dividers leave reset at zero together
      ref_run = 1'b0;
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      cyc(4);
      chk("rst_prescaler", 8'(prescaler_modulus), 8'h08);
      chk("rst_fields", 8'({output_halve, halved_feedback_select, backlash_width}), 8'h00);
      // reference ratio 24 against 8*3+0: pulses pair up one cycle apart
      load(24'h000100, 2);
      load(24'h040061, 2);
      load(24'h000302, 2);
      ref_run = 1'b1;
      fb_run = 1'b1;
      nr = 0;
      nt = 0;
      nb = 0;
      for (i = 0; i < 3000 && lock_detect !== 1'b1; i++) begin
         cyc(1);
         if (ref_div_out === 1'b1) nr++;
         if (pump_up === 1'b1) nt++;
         if (pump_dn === 1'b1) nb++;
      end
      chk("lock_seen", 8'(lock_detect), 8'h01);
      chk("lock_pairs", 8'(nr), 8'h05);
      chk("pump_pulses", 8'({nt[3:0], nb[3:0]}), 8'h50);
      close_out();
   end
endmodule
